// file: rkpb_map.vh
/*
  register map, field layout and reset values of the kernel program
  base register block. assumes inclusion by its bare name.
*/
`ifndef RKPB_MAP_VH
`define RKPB_MAP_VH

// ==========================================================
// register offsets (byte addresses)
`define RKPB_OFF_BASE      12'h000
`define RKPB_OFF_RAM_SIZE  12'h004
`define RKPB_OFF_STATUS    12'h008

// ==========================================================
// fields
`define RKPB_BASE_MSB      15
`define RKPB_BASE_LSB      10
`define RKPB_BASE_W        6
`define RKPB_SIZE_MSB      31
`define RKPB_SIZE_LSB      0

// ==========================================================
// reset values
`define RKPB_BASE_RST      6'h00
`define RKPB_SIZE_RST      32'h00004000

`endif

// file: rkpb_monitor.sv
/* checker of rkpb_top ports; one pclk domain, reset active low */
`timescale 1ns/1ps
module rkpb_monitor (
  input logic        pclk,
  input logic        presetn,
  input logic        psel,
  input logic        penable,
  input logic        pwrite,
  input logic        pready,
  input logic        pslverr,
  input logic [11:0] paddr,
  input logic [31:0] pwdata,
  input logic [31:0] prdata,
  input logic [31:0] kernel_prog_base
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire wr = psel & penable & pready & pwrite & !paddr;
  sequence s_setup;
    psel & !penable;
  endsequence
  sequence s_answer;
    pready ##1 !pready;
  endsequence
  a_ready_answer: assert property (s_setup |=> s_answer)
    else $error("no single ready pulse after setup");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_base_hold: assert property (!wr |=> $stable(kernel_prog_base))
    else $error("base moved without a base write");
  a_read_pad: assert property (psel & penable & pready & !pwrite & !paddr
    |-> !(prdata & 32'hffff03ff)) else $error("pad");
  a_base_wr: assert property (wr |=> kernel_prog_base == ($past(pwdata) & 32'hfc00))
    else $error("write");
  a_reset_clr: assert property ($rose(presetn) |-> !kernel_prog_base) else $error("rst");
endmodule // rkpb_monitor

// file: rkpb_top.v
/*
  kernel program base register of the data ram partition, as an apb slave.
  assumes a synchronous apb master on pclk; software keeps base <= ram size.
*/
// Function
// - bits 31 to 16 of the base register read zero and store nothing
// - six-bit read/write field at bits 15:10 sets kernel program base
// - bits 9 to 0 read constant zero, base moves in 1 KB steps
// - reset forces the base register to zero, all ram is kernel data
`timescale 1ns/1ps
`include "rkpb_map.vh"

module rkpb_top (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  output reg  [31:0] kernel_prog_base,
  output reg         base_over_size
);

  // ========================================================
  // constants
  localparam [31:0] WORD_ZERO = 32'h00000000;

  // ========================================================
  // bus phase states
  // the slave answers in the cycle after setup, so one state is enough
  // to tell the answer cycle apart from idle; no wait states are added
  localparam [1:0] ST_IDLE   = 2'b00;
  localparam [1:0] ST_ANSWER = 2'b01;

  // ========================================================
  // register indices
  localparam [1:0] SEL_NONE  = 2'b00;
  localparam [1:0] SEL_BASE  = 2'b01;
  localparam [1:0] SEL_SIZE  = 2'b10;
  localparam [1:0] SEL_STAT  = 2'b11;

  // ========================================================
  // phase state
  reg  [1:0]              phase_r;
  reg  [1:0]              phase_nxt;

  // ========================================================
  // register state
  reg  [`RKPB_BASE_W-1:0] base_r;
  reg  [`RKPB_BASE_W-1:0] base_nxt;
  reg  [31:0]             ram_size_r;
  reg  [31:0]             ram_size_nxt;

  // ========================================================
  // bus decode and answer
  // words handed between the decode and the flops
  reg  [1:0]              sel_nxt;
  reg                     hit_nxt;
  reg  [31:0]             rdata_nxt;
  reg  [31:0]             prdata_nxt;
  reg                     pready_nxt;
  reg                     pslverr_nxt;
  reg                     over_nxt;
  wire                    setup_w;
  wire                    access_w;
  wire                    wr_w;
  wire                    wr_base_w;
  wire                    wr_size_w;
  wire [31:0]             base_full_w;
  wire [31:0]             base_nxt_full_w;

  // ========================================================
  // helpers
  // zero-extended byte address from the six-bit field
  function [31:0] rkpb_expand;
    input [`RKPB_BASE_W-1:0] f;
    begin
      rkpb_expand = {16'h0000, f, 10'h000};
    end
  endfunction

  // byte address to register index; anything unmapped is refused
  function [1:0] rkpb_decode;
    input [11:0] a;
    begin
      case (a)
        `RKPB_OFF_BASE:     rkpb_decode = SEL_BASE;
        `RKPB_OFF_RAM_SIZE: rkpb_decode = SEL_SIZE;
        `RKPB_OFF_STATUS:   rkpb_decode = SEL_STAT;
        default:            rkpb_decode = SEL_NONE;
      endcase
    end
  endfunction

  // writable field of a write word; every other bit is dropped
  function [`RKPB_BASE_W-1:0] rkpb_field;
    input [31:0] d;
    begin
      rkpb_field = d[`RKPB_BASE_MSB:`RKPB_BASE_LSB];
    end
  endfunction

  // status word, flag in bit zero
  function [31:0] rkpb_status;
    input flag;
    begin
      rkpb_status = {{31{1'b0}}, flag};
    end
  endfunction

  // ========================================================
  // bus qualifiers
  // a write lands only on the edge that samples pready high
  assign setup_w         = psel & ~penable;
  assign access_w        = psel & penable & pready;
  assign wr_w            = access_w & pwrite & ~pslverr;
  assign wr_base_w       = wr_w & (rkpb_decode(paddr) == SEL_BASE);
  assign wr_size_w       = wr_w & (rkpb_decode(paddr) == SEL_SIZE);
  assign base_full_w     = rkpb_expand(base_r);
  assign base_nxt_full_w = rkpb_expand(base_nxt);

  // ========================================================
  // register select
  always @* begin
    sel_nxt = rkpb_decode(paddr);
    hit_nxt = (sel_nxt != SEL_NONE);
  end

  // ========================================================
  // read mux
  always @* begin
    rdata_nxt = WORD_ZERO;
    case (sel_nxt)
      SEL_BASE: begin
        rdata_nxt = base_full_w;
      end
      SEL_SIZE: begin
        rdata_nxt = ram_size_r;
      end
      SEL_STAT: begin
        rdata_nxt = rkpb_status(base_over_size);
      end
      default: begin
        rdata_nxt = WORD_ZERO;
      end
    endcase
  end

  // ========================================================
  // write update
  // writes to the status word fall through and change nothing
  always @* begin
    base_nxt     = base_r;
    ram_size_nxt = ram_size_r;
    if (wr_base_w) begin
      base_nxt = rkpb_field(pwdata);
    end
    if (wr_size_w) begin
      ram_size_nxt = pwdata;
    end
  end

  // ========================================================
  // bus phase
  // a setup cycle straight after an answer starts the next transfer at once
  always @* begin
    phase_nxt = phase_r;
    case (phase_r)
      ST_IDLE: begin
        if (setup_w) begin
          phase_nxt = ST_ANSWER;
        end
      end
      ST_ANSWER: begin
        if (setup_w) begin
          phase_nxt = ST_ANSWER;
        end else begin
          phase_nxt = ST_IDLE;
        end
      end
      default: begin
        phase_nxt = ST_IDLE;
      end
    endcase
  end

  // ========================================================
  // ready next
  always @* begin
    pready_nxt = (phase_nxt == ST_ANSWER);
  end

  // ========================================================
  // error next
  always @* begin
    pslverr_nxt = setup_w & ~hit_nxt;
  end

  // ========================================================
  // read data next
  // held until the next read so a slow master still sees it
  always @* begin
    prdata_nxt = prdata;
    if (setup_w && !pwrite) begin
      prdata_nxt = rdata_nxt;
    end
  end

  // ========================================================
  // size limit flag next
  // flags software breaking the size limit; hardware cannot refuse it
  always @* begin
    over_nxt = (base_nxt_full_w > ram_size_nxt);
  end

  // ========================================================
  // phase register
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_r <= ST_IDLE;
    end else begin
      phase_r <= phase_nxt;
    end
  end

  // ========================================================
  // base field register
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      base_r <= `RKPB_BASE_RST;
    end else begin
      base_r <= base_nxt;
    end
  end

  // ========================================================
  // ram size register
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ram_size_r <= `RKPB_SIZE_RST;
    end else begin
      ram_size_r <= ram_size_nxt;
    end
  end

  // ========================================================
  // kernel program base output
  // a registered copy, so no logic sits between the flop and the pin
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      kernel_prog_base <= WORD_ZERO;
    end else begin
      kernel_prog_base <= base_nxt_full_w;
    end
  end

  // ========================================================
  // size limit flag
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      base_over_size <= 1'b0;
    end else begin
      base_over_size <= over_nxt;
    end
  end

  // ========================================================
  // read data
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= WORD_ZERO;
    end else begin
      prdata <= prdata_nxt;
    end
  end

  // ========================================================
  // ready
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= pready_nxt;
    end
  end

  // ========================================================
  // error response
  // unmapped addresses answer with an error and leave every register alone
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= pslverr_nxt;
    end
  end

endmodule // rkpb_top

// file: testbench.sv
/* bench of rkpb_top: apb master, read and base-output checks;
   assumes the register map header next to it */
`timescale 1ns/1ps
`include "rkpb_map.vh"
module testbench;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic        pready, pslverr, base_over_size, kwait = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, kernel_prog_base, sz = `RKPB_SIZE_RST;
  logic [32:0] q[$], kq[$];
  int          n_mismatch = 0, checks_done = 0;
  rkpb_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .kernel_prog_base(kernel_prog_base), .base_over_size(base_over_size));
  initial forever #5 pclk = ~pclk;
  task automatic chk_rd(logic [32:0] g, e);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %0t read got %h exp %h", $time, g, e);
    end
  endtask
  task automatic chk_base(logic [32:0] g, e);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %0t base out got %h exp %h", $time, g, e);
    end
  endtask
  always @(posedge pclk) begin
    if (psel & penable & pready & !pwrite) chk_rd({pslverr, prdata}, q.pop_front());
    if (kwait) chk_base({base_over_size, kernel_prog_base}, kq.pop_front());
    kwait <= psel & penable & pready & pwrite & (paddr == `RKPB_OFF_BASE);
  end
  task automatic apb(logic wr, logic [11:0] a, logic [31:0] d, logic [32:0] e);
    int n = 0;
    if (!wr) q.push_back(e);
    if (wr && a == `RKPB_OFF_RAM_SIZE) sz = d;
    if (wr && a == `RKPB_OFF_BASE) kq.push_back({(d & 32'h0000fc00) > sz, d & 32'h0000fc00});
    @(posedge pclk) {psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, d};
    @(posedge pclk) penable <= 1;
    do @(posedge pclk); while (pready !== 1 && ++n < 20);
    {psel, penable} <= 2'b00;
    if (n == 20) begin n_mismatch++; summarize; end
  endtask
  initial begin
    logic [31:0] d;
    void'($urandom(2));
    repeat (5) @(posedge pclk);
    presetn <= 1;
    apb(0, `RKPB_OFF_BASE, 0, 0);
    apb(0, `RKPB_OFF_STATUS, 0, 0);
    repeat (9) begin
      // pad bits forced high so that masking is seen; base kept within size
      d = 32'hffff03ff | (($urandom % 17) << 10);
      apb(1, `RKPB_OFF_BASE, d, 0);
      apb(0, `RKPB_OFF_BASE, 0, {1'b0, d & 32'h0000fc00});
    end
    apb(1, `RKPB_OFF_BASE, 32'h00000800, 0);
    apb(1, `RKPB_OFF_RAM_SIZE, 32'h00000400, 0);
    apb(0, `RKPB_OFF_RAM_SIZE, 0, {1'b0, 32'h00000400});
    apb(0, `RKPB_OFF_STATUS, 0, {1'b0, 32'h00000001});
    apb(1, `RKPB_OFF_BASE, 32'h00000400, 0);
    apb(0, `RKPB_OFF_STATUS, 0, 0);
    apb(0, 12'h00c, 0, {1'b1, 32'h00000000});
    apb(1, 12'h00c, 32'hffffffff, 0);
    apb(0, `RKPB_OFF_BASE, 0, {1'b0, 32'h00000400});
    @(posedge pclk) presetn <= 0;
    repeat (2) @(posedge pclk);
    presetn <= 1;
    sz = `RKPB_SIZE_RST;
    apb(0, `RKPB_OFF_BASE, 0, 0);
    apb(0, `RKPB_OFF_RAM_SIZE, 0, {1'b0, `RKPB_SIZE_RST});
    summarize;
  end
  task automatic summarize;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
endmodule // testbench
bind rkpb_top rkpb_monitor mon (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .pready(pready), .pslverr(pslverr), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .kernel_prog_base(kernel_prog_base));
